// ### design/ecs_encoder_config.sv
// Notes on behaviour
// - Selector codes 0 user, 1 resolver, 2 serial, 4 incremental, 3/5 resolver mixes.
// - Writing reference-input settings forces the selector to user defined.
// - Selected combination is latched only at start-up initialization.
// - Angle input is resolver or sine/cosine; resolver by default.
// - Reinitialize after reconfiguring; sine/cosine mode turns resolver excitation off.
// - Sine/cosine evaluation gives 10-bit angle resolution instead of 12.
// - Resolver pole pairs accept 1 to 80, default 1.
// - 16-bit rotor zero offset, default zero, added to commutation angle.
// - Offset determination energizes the motor.
// - Correction mode 0 applies no track correction.
// - Mode 1 corrects with fixed stored coefficients.
// - Mode 2 adapts online only at or above sample_hz*60/500 rpm.
// - Writing 3 resets coefficients to factory; active mode unchanged.
// - Incremental line count 32 to 8192, default 1024.
// - Multiturn bits 0..16 default 12; singleturn bits 0..20 default 13.
// - Ratio numerator signed, denominator 1..65535, both default 1.
// - Incremental and serial settings share storage with the reference input.
`timescale 1ns/1ps
`default_nettype none
module ecs_encoder_config #(
  parameter int SAMPLE_HZ = 4000,
  parameter int ANGLE_W = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic init_req,
  input wire logic combo_wr,
  input wire logic [2:0] combo_wdata,
  input wire logic angle_cfg_wr,
  input wire logic angle_cfg_sine_cosine_input,
  input wire logic pole_pairs_wr,
  input wire logic [6:0] pole_pairs_wdata,
  input wire logic offset_wr,
  input wire logic [15:0] offset_wdata,
  input wire logic corr_wr,
  input wire logic [1:0] corr_wdata,
  input wire logic lines_wr,
  input wire logic [13:0] lines_wdata,
  input wire logic multi_wr,
  input wire logic [4:0] multi_wdata,
  input wire logic single_wr,
  input wire logic [4:0] single_wdata,
  input wire logic num_wr,
  input wire logic [15:0] num_wdata,
  input wire logic den_wr,
  input wire logic [15:0] den_wdata,
  input wire logic ref_input_wr,
  input wire logic offset_detect_req,
  input wire logic [ANGLE_W-1:0] raw_angle,
  input wire logic [15:0] speed_rpm,
  output logic [2:0] combo_select,
  output logic [1:0] motor_sensor,
  output logic [1:0] position_sensor,
  output logic sine_cosine_input_active,
  output logic excitation_en,
  output logic [3:0] angle_res_bits,
  output logic [6:0] resolver_pole_pairs,
  output logic [15:0] rotor_zero_offset,
  output logic [1:0] track_correction_mode,
  output logic correction_en,
  output logic online_tuning,
  output logic coeff_factory_reset,
  output logic [13:0] incremental_line_count,
  output logic [4:0] serial_multiturn_bits,
  output logic [4:0] serial_singleturn_bits,
  output logic [15:0] ratio_numerator,
  output logic [15:0] ratio_denominator,
  output logic motor_energize,
  output logic [ANGLE_W-1:0] commutation_angle
);

  localparam int ONLINE_TUNING_RPM_I = SAMPLE_HZ * ecs_pkg::ONLINE_TUNING_SPEED_MUL / ecs_pkg::ONLINE_TUNING_SPEED_DIV;
  localparam logic [15:0] ONLINE_TUNING_RPM = 16'(ONLINE_TUNING_RPM_I);

  if (ANGLE_W < 16 || SAMPLE_HZ < 1 || ONLINE_TUNING_RPM_I > 65535) begin : g_param_check
    $error("ecs_encoder_config: unsupported parameter values");
  end

  // ****************************************************************
  // Decoding
  // ****************************************************************

  // Returns {motor sensor, position sensor}; zero for undefined codes.
  function automatic logic [3:0] combo_decode(input logic [2:0] code);
    unique case (code)
      ecs_pkg::COMBO_RESOLVER_BOTH: combo_decode = {ecs_pkg::SENSOR_RESOLVER, ecs_pkg::SENSOR_RESOLVER};
      ecs_pkg::COMBO_SERIAL_BOTH: combo_decode = {ecs_pkg::SENSOR_SERIAL, ecs_pkg::SENSOR_SERIAL};
      ecs_pkg::COMBO_INCR_BOTH: combo_decode = {ecs_pkg::SENSOR_INCR, ecs_pkg::SENSOR_INCR};
      ecs_pkg::COMBO_RES_MOTOR_SERIAL_POS: combo_decode = {ecs_pkg::SENSOR_RESOLVER, ecs_pkg::SENSOR_SERIAL};
      ecs_pkg::COMBO_RES_MOTOR_INCR_POS: combo_decode = {ecs_pkg::SENSOR_RESOLVER, ecs_pkg::SENSOR_INCR};
      default: combo_decode = {ecs_pkg::SENSOR_NONE, ecs_pkg::SENSOR_NONE};
    endcase
  endfunction : combo_decode

  function automatic logic combo_legal(input logic [2:0] code);
    combo_legal = (code <= ecs_pkg::COMBO_RES_MOTOR_INCR_POS);
  endfunction : combo_legal

  // ****************************************************************
  // Stored settings
  // ****************************************************************

  logic [2:0] combo_r, combo_nxt;
  logic sine_cosine_input_r, sine_cosine_input_nxt;
  logic [6:0] pp_r, pp_nxt;
  logic [15:0] off_r, off_nxt;
  logic [1:0] corr_r, corr_nxt;
  logic frst_r, frst_nxt;
  logic [13:0] lines_r, lines_nxt;
  logic [4:0] multi_r, multi_nxt;
  logic [4:0] single_r, single_nxt;
  logic [15:0] num_r, num_nxt;
  logic [15:0] den_r, den_nxt;
  logic ref_touch;

  always_comb begin
    // Writes from the reference input land in the same storage.
    ref_touch = ref_input_wr && (lines_wr || multi_wr || single_wr || num_wr || den_wr);
    combo_nxt = combo_r;
    sine_cosine_input_nxt = sine_cosine_input_r;
    pp_nxt = pp_r;
    off_nxt = off_r;
    corr_nxt = corr_r;
    frst_nxt = 1'b0;
    lines_nxt = lines_r;
    multi_nxt = multi_r;
    single_nxt = single_r;
    num_nxt = num_r;
    den_nxt = den_r;
    if (ref_touch) begin
      combo_nxt = ecs_pkg::COMBO_USER;
    end else if (combo_wr && combo_legal(combo_wdata)) begin
      combo_nxt = combo_wdata;
    end
    if (angle_cfg_wr) begin
      sine_cosine_input_nxt = angle_cfg_sine_cosine_input;
    end
    if (pole_pairs_wr && pole_pairs_wdata >= ecs_pkg::POLE_PAIRS_MIN
        && pole_pairs_wdata <= ecs_pkg::POLE_PAIRS_MAX) begin
      pp_nxt = pole_pairs_wdata;
    end
    if (offset_wr) begin
      off_nxt = offset_wdata;
    end
    if (corr_wr) begin
      if (corr_wdata == ecs_pkg::CORR_FACTORY) begin
        frst_nxt = 1'b1;
      end else begin
        corr_nxt = corr_wdata;
      end
    end
    if (lines_wr && lines_wdata >= ecs_pkg::LINES_MIN && lines_wdata <= ecs_pkg::LINES_MAX) begin
      lines_nxt = lines_wdata;
    end
    if (multi_wr && multi_wdata <= ecs_pkg::MULTI_MAX) begin
      multi_nxt = multi_wdata;
    end
    if (single_wr && single_wdata <= ecs_pkg::SINGLE_MAX) begin
      single_nxt = single_wdata;
    end
    if (num_wr) begin
      num_nxt = num_wdata;
    end
    if (den_wr && den_wdata >= ecs_pkg::DEN_MIN) begin
      den_nxt = den_wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      combo_r <= ecs_pkg::COMBO_RESET;
      sine_cosine_input_r <= 1'b0;
      pp_r <= ecs_pkg::POLE_PAIRS_RESET;
      off_r <= ecs_pkg::OFFSET_RESET;
      corr_r <= ecs_pkg::CORR_OFF;
      frst_r <= 1'b0;
      lines_r <= ecs_pkg::LINES_RESET;
      multi_r <= ecs_pkg::MULTI_RESET;
      single_r <= ecs_pkg::SINGLE_RESET;
      num_r <= ecs_pkg::NUM_RESET;
      den_r <= ecs_pkg::DEN_RESET;
    end else begin
      combo_r <= combo_nxt;
      sine_cosine_input_r <= sine_cosine_input_nxt;
      pp_r <= pp_nxt;
      off_r <= off_nxt;
      corr_r <= corr_nxt;
      frst_r <= frst_nxt;
      lines_r <= lines_nxt;
      multi_r <= multi_nxt;
      single_r <= single_nxt;
      num_r <= num_nxt;
      den_r <= den_nxt;
    end
  end

  // ****************************************************************
  // Start-up latch of the active configuration
  // ****************************************************************

  logic [3:0] roles_r, roles_nxt;
  logic act_sine_cosine_input_r, act_sine_cosine_input_nxt;
  logic [15:0] act_off_r, act_off_nxt;

  always_comb begin
    roles_nxt = roles_r;
    act_sine_cosine_input_nxt = act_sine_cosine_input_r;
    act_off_nxt = act_off_r;
    if (init_req) begin
      roles_nxt = combo_decode(combo_r);
      act_sine_cosine_input_nxt = sine_cosine_input_r;
      act_off_nxt = off_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      roles_r <= {ecs_pkg::SENSOR_RESOLVER, ecs_pkg::SENSOR_RESOLVER};
      act_sine_cosine_input_r <= 1'b0;
      act_off_r <= ecs_pkg::OFFSET_RESET;
    end else begin
      roles_r <= roles_nxt;
      act_sine_cosine_input_r <= act_sine_cosine_input_nxt;
      act_off_r <= act_off_nxt;
    end
  end

  // ****************************************************************
  // Derived outputs
  // ****************************************************************

  logic tune_nxt, cen_nxt, exc_nxt, energ_nxt;
  logic [3:0] res_nxt;
  logic [ANGLE_W-1:0] comm_nxt;
  logic tune_r, cen_r, exc_r, energ_r;
  logic [3:0] res_r;
  logic [ANGLE_W-1:0] comm_r;

  always_comb begin
    cen_nxt = (corr_r != ecs_pkg::CORR_OFF);
    tune_nxt = (corr_r == ecs_pkg::CORR_ONLINE_TUNING) && (speed_rpm >= ONLINE_TUNING_RPM);
    exc_nxt = !act_sine_cosine_input_r;
    res_nxt = act_sine_cosine_input_r ? ecs_pkg::RES_BITS_SINE_COSINE_INPUT : ecs_pkg::RES_BITS_RESOLVER;
    energ_nxt = offset_detect_req;
    comm_nxt = raw_angle + (ANGLE_W'(act_off_r) << (ANGLE_W - 16));
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cen_r <= 1'b0;
      tune_r <= 1'b0;
      exc_r <= 1'b1;
      res_r <= ecs_pkg::RES_BITS_RESOLVER;
      energ_r <= 1'b0;
      comm_r <= '0;
    end else begin
      cen_r <= cen_nxt;
      tune_r <= tune_nxt;
      exc_r <= exc_nxt;
      res_r <= res_nxt;
      energ_r <= energ_nxt;
      comm_r <= comm_nxt;
    end
  end

  assign combo_select = combo_r;
  assign motor_sensor = roles_r[3:2];
  assign position_sensor = roles_r[1:0];
  assign sine_cosine_input_active = act_sine_cosine_input_r;
  assign excitation_en = exc_r;
  assign angle_res_bits = res_r;
  assign resolver_pole_pairs = pp_r;
  assign rotor_zero_offset = off_r;
  assign track_correction_mode = corr_r;
  assign correction_en = cen_r;
  assign online_tuning = tune_r;
  assign coeff_factory_reset = frst_r;
  assign incremental_line_count = lines_r;
  assign serial_multiturn_bits = multi_r;
  assign serial_singleturn_bits = single_r;
  assign ratio_numerator = num_r;
  assign ratio_denominator = den_r;
  assign motor_energize = energ_r;
  assign commutation_angle = comm_r;

  // ****************************************************************
  // Checks
  // ****************************************************************

  a_mode_three_kept: assert property (@(posedge clk) disable iff (!reset_n)
    corr_wr && corr_wdata == ecs_pkg::CORR_FACTORY |=> $stable(corr_r) && frst_r)
    else $error("Factory reset changed the correction mode.");
  a_combo_legal_only: assert property (@(posedge clk) disable iff (!reset_n)
    combo_wr && !combo_legal(combo_wdata) && !ref_touch |=> $stable(combo_r))
    else $error("Illegal selector code was stored.");
  a_ref_forces_user: assert property (@(posedge clk) disable iff (!reset_n)
    ref_touch |=> combo_r == ecs_pkg::COMBO_USER)
    else $error("Reference write did not force user mode.");
  a_roles_only_init: assert property (@(posedge clk) disable iff (!reset_n)
    !init_req |=> $stable(roles_r))
    else $error("Roles changed without initialization.");
  a_excite_off_sine_cosine_input: assert property (@(posedge clk) disable iff (!reset_n)
    init_req && sine_cosine_input_r |=> ##1 !exc_r && res_r == ecs_pkg::RES_BITS_SINE_COSINE_INPUT)
    else $error("Excitation or resolution wrong in sine/cosine mode.");
  a_pole_range: assert property (@(posedge clk) disable iff (!reset_n)
    pp_r >= ecs_pkg::POLE_PAIRS_MIN && pp_r <= ecs_pkg::POLE_PAIRS_MAX)
    else $error("Pole pair count out of range.");
  a_lines_range: assert property (@(posedge clk) disable iff (!reset_n)
    lines_r >= ecs_pkg::LINES_MIN && lines_r <= ecs_pkg::LINES_MAX)
    else $error("Line count out of range.");
  a_tune_speed: assert property (@(posedge clk) disable iff (!reset_n)
    tune_r |-> $past(speed_rpm) >= ONLINE_TUNING_RPM && $past(corr_r) == ecs_pkg::CORR_ONLINE_TUNING)
    else $error("Adaptation ran below minimum speed.");
  a_bits_range: assert property (@(posedge clk) disable iff (!reset_n)
    multi_r <= ecs_pkg::MULTI_MAX && single_r <= ecs_pkg::SINGLE_MAX && den_r != 16'h0000)
    else $error("Serial width or denominator out of range.");
  c_init_sine_cosine_input: cover property (@(posedge clk) disable iff (!reset_n) init_req && sine_cosine_input_r);
  c_factory_rst: cover property (@(posedge clk) disable iff (!reset_n) frst_r);
  c_tuning: cover property (@(posedge clk) disable iff (!reset_n) tune_r);
  c_user_forced: cover property (@(posedge clk) disable iff (!reset_n) ref_touch);

endmodule : ecs_encoder_config
`default_nettype wire

// ### design/ecs_pkg.sv
`default_nettype none
package ecs_pkg;

  // Encoder combination codes.
  localparam logic [2:0] COMBO_USER = 3'h0;
  localparam logic [2:0] COMBO_RESOLVER_BOTH = 3'h1;
  localparam logic [2:0] COMBO_SERIAL_BOTH = 3'h2;
  localparam logic [2:0] COMBO_RES_MOTOR_SERIAL_POS = 3'h3;
  localparam logic [2:0] COMBO_INCR_BOTH = 3'h4;
  localparam logic [2:0] COMBO_RES_MOTOR_INCR_POS = 3'h5;
  localparam logic [2:0] COMBO_RESET = COMBO_RESOLVER_BOTH;

  // Track correction mode codes.
  localparam logic [1:0] CORR_OFF = 2'h0;
  localparam logic [1:0] CORR_FIXED = 2'h1;
  localparam logic [1:0] CORR_ONLINE_TUNING = 2'h2;
  localparam logic [1:0] CORR_FACTORY = 2'h3;

  // Sensor kinds feeding each role.
  localparam logic [1:0] SENSOR_NONE = 2'h0;
  localparam logic [1:0] SENSOR_RESOLVER = 2'h1;
  localparam logic [1:0] SENSOR_SERIAL = 2'h2;
  localparam logic [1:0] SENSOR_INCR = 2'h3;

  // Ranges and defaults.
  localparam logic [6:0] POLE_PAIRS_MIN = 7'h01;
  localparam logic [6:0] POLE_PAIRS_MAX = 7'h50;
  localparam logic [6:0] POLE_PAIRS_RESET = 7'h01;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [13:0] LINES_MIN = 14'h0020;
  localparam logic [13:0] LINES_MAX = 14'h2000;
  localparam logic [13:0] LINES_RESET = 14'h0400;
  localparam logic [4:0] MULTI_MAX = 5'h10;
  localparam logic [4:0] MULTI_RESET = 5'h0c;
  localparam logic [4:0] SINGLE_MAX = 5'h14;
  localparam logic [4:0] SINGLE_RESET = 5'h0d;
  localparam logic [15:0] NUM_RESET = 16'h0001;
  localparam logic [15:0] DEN_MIN = 16'h0001;
  localparam logic [15:0] DEN_RESET = 16'h0001;
  localparam logic [3:0] RES_BITS_RESOLVER = 4'hc;
  localparam logic [3:0] RES_BITS_SINE_COSINE_INPUT = 4'ha;
  // Adaptation speed threshold: rpm = sample_hz * 60 / 500.
  localparam int ONLINE_TUNING_SPEED_MUL = 60;
  localparam int ONLINE_TUNING_SPEED_DIV = 500;

endpackage : ecs_pkg
`default_nettype wire

// ### test/ecs_enc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Encoder front end seen by the config block.
// ****************************************
module ecs_enc_model #(
  parameter logic [15:0] ANG = 16'h1234
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic excitation_en,
  input wire logic sine_cosine_input_active,
  input wire logic [15:0] spd,
  output logic [15:0] raw_angle,
  output logic [15:0] speed_rpm
);
  // An unexcited resolver gives no track signals, so its angle is garbage.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      raw_angle <= ANG;
    end else if (excitation_en || sine_cosine_input_active) begin
      raw_angle <= ANG;
    end else begin
      raw_angle <= ~raw_angle;
    end
  end
  // Speeds stay far below what a magnetic scale would allow.
  assign speed_rpm = spd;
endmodule : ecs_enc_model
`default_nettype wire

// ### test/test_encoder_config_select.sv
`timescale 1ns/1ps
`default_nettype none
module test_encoder_config_select;
  localparam int THR = 4000 * ecs_pkg::ONLINE_TUNING_SPEED_MUL / ecs_pkg::ONLINE_TUNING_SPEED_DIV;
  localparam logic [15:0] ANG = 16'h1234;
  localparam logic [11:0] W_CO = 12'h001, W_AN = 12'h002, W_PP = 12'h004, W_OF = 12'h008,
    W_CR = 12'h010, W_LN = 12'h020, W_MU = 12'h040, W_SI = 12'h080, W_NU = 12'h100,
    W_DE = 12'h200, W_IN = 12'h400, W_RF = 12'h800;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] wr_v = '0;
  logic [15:0] wd = '0;
  logic det = 1'b0;
  logic [15:0] spd = '0;
  logic [15:0] raw_angle, speed_rpm, rotor_zero_offset, ratio_numerator, ratio_denominator;
  logic [15:0] commutation_angle;
  logic [13:0] incremental_line_count;
  logic [6:0] resolver_pole_pairs;
  logic [4:0] serial_multiturn_bits, serial_singleturn_bits;
  logic [3:0] angle_res_bits;
  logic [2:0] combo_select;
  logic [1:0] motor_sensor, position_sensor, track_correction_mode;
  logic sine_cosine_input_active, excitation_en, correction_en, online_tuning, coeff_factory_reset;
  logic motor_energize;
  int fail_count = 0;
  int n_checks = 0;
  logic [1:0] em [6] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h3, 2'h1};
  logic [1:0] ep [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};

  always #12.5 clk = ~clk;

  ecs_enc_model #(.ANG(ANG)) mdl_u (.clk(clk), .reset_n(reset_n), .excitation_en(excitation_en),
    .sine_cosine_input_active(sine_cosine_input_active), .spd(spd), .raw_angle(raw_angle), .speed_rpm(speed_rpm));

  ecs_encoder_config #(.SAMPLE_HZ(4000), .ANGLE_W(16)) dut_u (.clk(clk), .reset_n(reset_n),
    .init_req(wr_v[10]), .combo_wr(wr_v[0]), .combo_wdata(wd[2:0]), .angle_cfg_wr(wr_v[1]),
    .angle_cfg_sine_cosine_input(wd[0]), .pole_pairs_wr(wr_v[2]), .pole_pairs_wdata(wd[6:0]),
    .offset_wr(wr_v[3]), .offset_wdata(wd), .corr_wr(wr_v[4]), .corr_wdata(wd[1:0]),
    .lines_wr(wr_v[5]), .lines_wdata(wd[13:0]), .multi_wr(wr_v[6]), .multi_wdata(wd[4:0]),
    .single_wr(wr_v[7]), .single_wdata(wd[4:0]), .num_wr(wr_v[8]), .num_wdata(wd),
    .den_wr(wr_v[9]), .den_wdata(wd), .ref_input_wr(wr_v[11]), .offset_detect_req(det),
    .raw_angle(raw_angle), .speed_rpm(speed_rpm), .combo_select(combo_select),
    .motor_sensor(motor_sensor), .position_sensor(position_sensor),
    .sine_cosine_input_active(sine_cosine_input_active), .excitation_en(excitation_en),
    .angle_res_bits(angle_res_bits), .resolver_pole_pairs(resolver_pole_pairs),
    .rotor_zero_offset(rotor_zero_offset), .track_correction_mode(track_correction_mode),
    .correction_en(correction_en), .online_tuning(online_tuning),
    .coeff_factory_reset(coeff_factory_reset), .incremental_line_count(incremental_line_count),
    .serial_multiturn_bits(serial_multiturn_bits),
    .serial_singleturn_bits(serial_singleturn_bits), .ratio_numerator(ratio_numerator),
    .ratio_denominator(ratio_denominator), .motor_energize(motor_energize),
    .commutation_angle(commutation_angle));

  // ************
  // Bench tasks.
  // ************
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One setting write; the new value is visible when the task returns.
  task automatic wr(input logic [11:0] m, input logic [15:0] d);
    @(posedge clk);
    wr_v <= m;
    wd <= d;
    @(posedge clk);
    wr_v <= '0;
    #1;
  endtask : wr

  task automatic init_cfg();
    wr(W_IN, 16'h0);
    @(posedge clk);
    #1;
  endtask : init_cfg

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    close_out();
  end

  // **************
  // Main sequence.
  // **************
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    chk("combo", 16'h1, combo_select);
    chk("excite", 16'h1, excitation_en);
    chk("res", 16'hc, angle_res_bits);
    chk("pairs", 16'h1, resolver_pole_pairs);
    chk("offset", 16'h0, rotor_zero_offset);
    chk("mode", 16'h0, track_correction_mode);
    chk("corr", 16'h0, correction_en);
    chk("lines", 16'h400, incremental_line_count);
    chk("multi", 16'hc, serial_multiturn_bits);
    chk("single", 16'hd, serial_singleturn_bits);
    chk("num", 16'h1, ratio_numerator);
    chk("den", 16'h1, ratio_denominator);
    wr(W_PP, 16'h50);
    chk("pairs", 16'h50, resolver_pole_pairs);
    wr(W_PP, 16'h51);
    chk("pairs", 16'h50, resolver_pole_pairs);
    wr(W_PP, 16'h0);
    chk("pairs", 16'h50, resolver_pole_pairs);
    wr(W_LN, 16'h2001);
    chk("lines", 16'h400, incremental_line_count);
    wr(W_LN, 16'h1f);
    chk("lines", 16'h400, incremental_line_count);
    wr(W_LN, 16'h20);
    chk("lines", 16'h20, incremental_line_count);
    wr(W_LN, 16'h2000);
    chk("lines", 16'h2000, incremental_line_count);
    wr(W_MU, 16'h11);
    chk("multi", 16'hc, serial_multiturn_bits);
    wr(W_MU, 16'h10);
    chk("multi", 16'h10, serial_multiturn_bits);
    wr(W_SI, 16'h15);
    chk("single", 16'hd, serial_singleturn_bits);
    wr(W_SI, 16'h14);
    chk("single", 16'h14, serial_singleturn_bits);
    wr(W_NU, 16'h8000);
    chk("num", 16'h8000, ratio_numerator);
    wr(W_DE, 16'h0);
    chk("den", 16'h1, ratio_denominator);
    wr(W_DE, 16'hffff);
    chk("den", 16'hffff, ratio_denominator);
    wr(W_CR, 16'h1);
    @(posedge clk);
    #1;
    chk("corr", 16'h1, correction_en);
    @(posedge clk);
    spd <= 16'(THR - 1);
    wr(W_CR, 16'h2);
    @(posedge clk);
    #1;
    chk("tune", 16'h0, online_tuning);
    @(posedge clk);
    spd <= 16'(THR);
    repeat (2) @(posedge clk);
    #1;
    chk("tune", 16'h1, online_tuning);
    wr(W_CR, 16'h3);
    chk("factory", 16'h1, coeff_factory_reset);
    chk("mode", 16'h2, track_correction_mode);
    @(posedge clk);
    #1;
    chk("factory", 16'h0, coeff_factory_reset);
    wr(W_OF, 16'hffff);
    chk("offset", 16'hffff, rotor_zero_offset);
    chk("angle", ANG, commutation_angle);
    wr(W_AN, 16'h1);
    chk("excite", 16'h1, excitation_en);
    init_cfg();
    chk("sine_cosine_input", 16'h1, sine_cosine_input_active);
    chk("excite", 16'h0, excitation_en);
    chk("res", 16'ha, angle_res_bits);
    chk("angle", ANG + 16'hffff, commutation_angle);
    wr(W_AN, 16'h0);
    init_cfg();
    chk("excite", 16'h1, excitation_en);
    chk("res", 16'hc, angle_res_bits);
    for (int c = 0; c < 6; c++) begin
      wr(W_CO, 16'(c));
      chk("combo", 16'(c), combo_select);
      chk("motor", em[(c + 5) % 6], motor_sensor);
      init_cfg();
      chk("motor", em[c], motor_sensor);
      chk("position", ep[c], position_sensor);
    end
    wr(W_CO, 16'h6);
    chk("combo", 16'h5, combo_select);
    wr(W_RF | W_LN | W_CO, 16'h104);
    chk("combo", 16'h0, combo_select);
    chk("lines", 16'h104, incremental_line_count);
    @(posedge clk);
    det <= 1'b1;
    @(posedge clk);
    #1;
    chk("energize", 16'h1, motor_energize);
    @(posedge clk);
    det <= 1'b0;
    @(posedge clk);
    #1;
    chk("energize", 16'h0, motor_energize);
    close_out();
  end
endmodule : test_encoder_config_select
`default_nettype wire
